// >>> include/pickup_feed_pkg.sv
// Package: constants and types for the paper pickup and feed control
package pickup_feed_pkg;
   // Paper size codes
   localparam logic [3:0] SIZE_UNKNOWN = 4'h0;
   localparam logic [3:0] SIZE_A4 = 4'h1;
   localparam logic [3:0] SIZE_LETTER = 4'h2;
   localparam logic [3:0] SIZE_B5 = 4'h3;
   localparam logic [3:0] SIZE_EXECUTIVE = 4'h4;
   localparam logic [3:0] SIZE_A5R = 4'h5;
   localparam logic [3:0] SIZE_B5R = 4'h6;
   localparam logic [3:0] SIZE_LETTER_R = 4'h7;
   localparam logic [3:0] SIZE_A4R = 4'h8;
   localparam logic [3:0] SIZE_A3 = 4'h9;
   localparam logic [3:0] SIZE_TABLOID = 4'ha;
   localparam logic [3:0] SIZE_B4 = 4'hb;
   localparam logic [3:0] SIZE_LEGAL = 4'hc;
   // Pickup source select
   localparam logic SRC_CASSETTE = 1'b0;
   localparam logic SRC_MANUAL = 1'b1;
   // Motor speed codes
   localparam logic [1:0] SPEED_OFF = 2'h0;
   localparam logic [1:0] SPEED_FEED = 2'h1;
   localparam logic [1:0] SPEED_ALIGN = 2'h2;
   // Timing in microseconds, clock at 250 MHz
   localparam int CLK_MHZ = 250;
   localparam int LIFT_TIMEOUT_US = 5000000;
   localparam int LIFT_TIMEOUT_CYC = LIFT_TIMEOUT_US * CLK_MHZ;
   localparam int SOL_DELAY_US = 10000;
   localparam int SOL_DELAY_CYC = SOL_DELAY_US * CLK_MHZ;
   localparam int SOL_ON_US = 20000;
   localparam int SOL_ON_CYC = SOL_ON_US * CLK_MHZ;
   localparam int ALIGN_US = 20000;
   localparam int ALIGN_CYC = ALIGN_US * CLK_MHZ;
   localparam int CNT_W = 32;
   typedef enum logic [4:0] {
      FEED_IDLE = 5'b00001,
      FEED_MOTOR = 5'b00010,
      FEED_SOL = 5'b00100,
      FEED_WAIT_TOP = 5'b01000,
      FEED_MEASURE = 5'b10000
   } feed_state_type;
   typedef enum logic [2:0] {
      LIFT_IDLE = 3'b001,
      LIFT_RUN = 3'b010,
      LIFT_FAIL = 3'b100
   } lift_state_type;
endpackage : pickup_feed_pkg

// >>> src/paper_pickup_feed_control.sv
// Engine-side pickup, lift-up, size decode and feed timing control
`timescale 1ns/10ps
module paper_pickup_feed_control #(
   parameter int LIFT_TIMEOUT = pickup_feed_pkg::LIFT_TIMEOUT_CYC,
   parameter int SOL_DELAY = pickup_feed_pkg::SOL_DELAY_CYC,
   parameter int SOL_ON = pickup_feed_pkg::SOL_ON_CYC,
   parameter int ALIGN_TIME = pickup_feed_pkg::ALIGN_CYC,
   parameter int LEN_TOL = 1000
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic print_cmd,
   input wire logic print_src,
   input wire logic [pickup_feed_pkg::CNT_W-1:0] expected_len,
   input wire logic stack_sensor_pin,
   input wire logic [2:0] width_sw_pin,
   input wire logic [2:0] end_sw_pin,
   input wire logic media_out_pin,
   input wire logic last_sheet_pin,
   input wire logic page_top_pin,
   output logic lifter_motor,
   output logic lifter_fail,
   output logic pickup_motor_on,
   output logic [1:0] pickup_speed,
   output logic cassette_solenoid,
   output logic manual_solenoid,
   output logic cassette_absent,
   output logic [3:0] paper_size,
   output logic media_out,
   output logic manual_media_absent,
   output logic size_mismatch,
   output logic feed_busy
);
   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   logic [9:0] pins_sync;
   pin_sync #(.WIDTH(10)) u_sync (
      .clk(clk),
      .arst_n(arst_n),
      .pin({page_top_pin, last_sheet_pin, media_out_pin, end_sw_pin, width_sw_pin,
            stack_sensor_pin}),
      .level(pins_sync)
   );
   logic stack_hit;
   logic [2:0] width_sw;
   logic [2:0] end_sw;
   logic media_empty;
   logic last_sheet;
   logic page_top;
   assign stack_hit = pins_sync[0];
   assign width_sw = pins_sync[3:1];
   assign end_sw = pins_sync[6:4];
   assign media_empty = pins_sync[7];
   assign last_sheet = pins_sync[8];
   assign page_top = pins_sync[9];

   // ----------------------------------------
   // Size decode
   // ----------------------------------------
   // Switch order is {bottom, center, top}; unlisted codes read as unknown
   function automatic logic [3:0] decode_size(input logic [2:0] w, input logic [2:0] e);
      logic [3:0] s;
      s = pickup_feed_pkg::SIZE_UNKNOWN;
      if (e[2:1] == 2'b00) begin
         case (w)
            3'b111: s = pickup_feed_pkg::SIZE_A4;
            3'b011: s = pickup_feed_pkg::SIZE_LETTER;
            3'b001: s = pickup_feed_pkg::SIZE_B5;
            3'b000: s = pickup_feed_pkg::SIZE_EXECUTIVE;
            3'b110: s = pickup_feed_pkg::SIZE_A5R;
            3'b100: s = pickup_feed_pkg::SIZE_B5R;
            3'b101: s = pickup_feed_pkg::SIZE_LETTER_R;
            default: s = pickup_feed_pkg::SIZE_UNKNOWN;
         endcase
      end else if (e[2:1] == 2'b10) begin
         if (w == 3'b101) begin
            s = pickup_feed_pkg::SIZE_A4R;
         end
      end else if (e[2:1] == 2'b11) begin
         case (w)
            3'b111: s = pickup_feed_pkg::SIZE_A3;
            3'b011: s = pickup_feed_pkg::SIZE_TABLOID;
            3'b001: s = pickup_feed_pkg::SIZE_B4;
            3'b101: s = pickup_feed_pkg::SIZE_LEGAL;
            default: s = pickup_feed_pkg::SIZE_UNKNOWN;
         endcase
      end
      return s;
   endfunction : decode_size

   // ----------------------------------------
   // Lift-up and status
   // ----------------------------------------
   pickup_feed_pkg::lift_state_type lift_state;
   pickup_feed_pkg::lift_state_type next_lift_state;
   logic [pickup_feed_pkg::CNT_W-1:0] lift_cnt;
   logic [pickup_feed_pkg::CNT_W-1:0] next_lift_cnt;
   logic powered;
   logic absent_d;
   logic next_lifter_motor;
   logic next_lifter_fail;
   logic present;
   logic lift_start;
   assign present = !end_sw[0];
   // Power-up start on the first edge after reset, or absent-to-present insertion
   // Sync stages reset to present, so a missing cassette pulses the lifter for the sync latency
   assign lift_start = present && (!powered || absent_d);
   always_comb begin
      next_lift_state = lift_state;
      next_lift_cnt = lift_cnt;
      next_lifter_fail = lifter_fail;
      case (lift_state)
         pickup_feed_pkg::LIFT_IDLE: begin
            if (lift_start) begin
               next_lift_state = pickup_feed_pkg::LIFT_RUN;
               next_lift_cnt = '0;
               next_lifter_fail = 1'b0;
            end
         end
         pickup_feed_pkg::LIFT_RUN: begin
            next_lift_cnt = lift_cnt + 1'b1;
            if (!present) begin
               next_lift_state = pickup_feed_pkg::LIFT_IDLE;
            end else if (stack_hit) begin
               next_lift_state = pickup_feed_pkg::LIFT_IDLE;
            end else if (lift_cnt >= LIFT_TIMEOUT[pickup_feed_pkg::CNT_W-1:0] - 1'b1) begin
               next_lift_state = pickup_feed_pkg::LIFT_FAIL;
               next_lifter_fail = 1'b1;
            end
         end
         pickup_feed_pkg::LIFT_FAIL: begin
            // Failure holds until the cassette is pulled and reinserted
            if (!present) begin
               next_lift_state = pickup_feed_pkg::LIFT_IDLE;
            end
         end
         default: next_lift_state = pickup_feed_pkg::LIFT_IDLE;
      endcase
      next_lifter_motor = (next_lift_state == pickup_feed_pkg::LIFT_RUN);
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lift_state <= pickup_feed_pkg::LIFT_IDLE;
         lift_cnt <= '0;
         powered <= 1'b0;
         absent_d <= 1'b0;
         lifter_motor <= 1'b0;
         lifter_fail <= 1'b0;
         cassette_absent <= 1'b0;
         paper_size <= pickup_feed_pkg::SIZE_UNKNOWN;
         media_out <= 1'b0;
      end else begin
         lift_state <= next_lift_state;
         lift_cnt <= next_lift_cnt;
         powered <= 1'b1;
         absent_d <= !present;
         lifter_motor <= next_lifter_motor;
         lifter_fail <= next_lifter_fail;
         cassette_absent <= !present;
         paper_size <= present ? decode_size(width_sw, end_sw) : pickup_feed_pkg::SIZE_UNKNOWN;
         media_out <= present && media_empty;
      end
   end

   // ----------------------------------------
   // Pickup and feed sequence
   // ----------------------------------------
   pickup_feed_pkg::feed_state_type feed_state;
   pickup_feed_pkg::feed_state_type next_feed_state;
   logic [pickup_feed_pkg::CNT_W-1:0] feed_cnt;
   logic [pickup_feed_pkg::CNT_W-1:0] next_feed_cnt;
   logic [pickup_feed_pkg::CNT_W-1:0] len_cnt;
   logic [pickup_feed_pkg::CNT_W-1:0] next_len_cnt;
   logic [pickup_feed_pkg::CNT_W-1:0] exp_len;
   logic [pickup_feed_pkg::CNT_W-1:0] next_exp_len;
   logic src;
   logic next_src;
   logic next_cas_sol;
   logic next_man_sol;
   logic [1:0] next_speed;
   logic next_mismatch;
   logic next_manual_absent;
   logic top_d;
   // Mismatch only when outside expected +/- tolerance
   function automatic logic out_of_window(input logic [pickup_feed_pkg::CNT_W-1:0] len,
                                          input logic [pickup_feed_pkg::CNT_W-1:0] ref_len);
      logic [pickup_feed_pkg::CNT_W:0] hi;
      logic [pickup_feed_pkg::CNT_W:0] lo;
      hi = {1'b0, ref_len} + {1'b0, LEN_TOL[pickup_feed_pkg::CNT_W-1:0]};
      lo = {1'b0, ref_len} - {1'b0, LEN_TOL[pickup_feed_pkg::CNT_W-1:0]};
      if (ref_len < LEN_TOL[pickup_feed_pkg::CNT_W-1:0]) begin
         lo = '0;
      end
      return ({1'b0, len} > hi) || ({1'b0, len} < lo);
   endfunction : out_of_window
   always_comb begin
      next_feed_state = feed_state;
      next_feed_cnt = feed_cnt + 1'b1;
      next_len_cnt = len_cnt;
      next_exp_len = exp_len;
      next_src = src;
      next_cas_sol = 1'b0;
      next_man_sol = 1'b0;
      next_speed = pickup_speed;
      next_mismatch = size_mismatch;
      next_manual_absent = manual_media_absent;
      case (feed_state)
         pickup_feed_pkg::FEED_IDLE: begin
            next_speed = pickup_feed_pkg::SPEED_OFF;
            next_feed_cnt = '0;
            if (print_cmd) begin
               next_src = print_src;
               next_exp_len = expected_len;
               next_mismatch = 1'b0;
               next_speed = pickup_feed_pkg::SPEED_FEED;
               if (print_src == pickup_feed_pkg::SRC_MANUAL) begin
                  next_feed_state = pickup_feed_pkg::FEED_SOL;
                  next_man_sol = 1'b1;
               end else begin
                  next_feed_state = pickup_feed_pkg::FEED_MOTOR;
               end
            end
         end
         pickup_feed_pkg::FEED_MOTOR: begin
            if (feed_cnt >= SOL_DELAY[pickup_feed_pkg::CNT_W-1:0] - 1'b1) begin
               next_feed_state = pickup_feed_pkg::FEED_SOL;
               next_feed_cnt = '0;
               next_cas_sol = 1'b1;
            end
         end
         pickup_feed_pkg::FEED_SOL: begin
            next_cas_sol = (src == pickup_feed_pkg::SRC_CASSETTE);
            next_man_sol = (src == pickup_feed_pkg::SRC_MANUAL);
            if (feed_cnt >= SOL_ON[pickup_feed_pkg::CNT_W-1:0] - 1'b1) begin
               next_feed_state = pickup_feed_pkg::FEED_WAIT_TOP;
               next_cas_sol = 1'b0;
               next_man_sol = 1'b0;
            end
         end
         pickup_feed_pkg::FEED_WAIT_TOP: begin
            if (page_top && !top_d) begin
               next_feed_state = pickup_feed_pkg::FEED_MEASURE;
               next_speed = pickup_feed_pkg::SPEED_ALIGN;
               next_len_cnt = '0;
               next_feed_cnt = '0;
            end
         end
         pickup_feed_pkg::FEED_MEASURE: begin
            next_len_cnt = len_cnt + 1'b1;
            if (feed_cnt >= ALIGN_TIME[pickup_feed_pkg::CNT_W-1:0] - 1'b1) begin
               next_speed = pickup_feed_pkg::SPEED_FEED;
            end
            if (!page_top) begin
               next_feed_state = pickup_feed_pkg::FEED_IDLE;
               next_speed = pickup_feed_pkg::SPEED_OFF;
               next_mismatch = out_of_window(len_cnt, exp_len);
            end
         end
         default: next_feed_state = pickup_feed_pkg::FEED_IDLE;
      endcase
      // Last-sheet trip sets the flag only during a manual feed; cleared by a new manual command
      if (src == pickup_feed_pkg::SRC_MANUAL && feed_state != pickup_feed_pkg::FEED_IDLE
          && last_sheet) begin
         next_manual_absent = 1'b1;
      end else if (feed_state == pickup_feed_pkg::FEED_IDLE && print_cmd
                   && print_src == pickup_feed_pkg::SRC_MANUAL) begin
         next_manual_absent = 1'b0;
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         feed_state <= pickup_feed_pkg::FEED_IDLE;
         feed_cnt <= '0;
         len_cnt <= '0;
         exp_len <= '0;
         src <= pickup_feed_pkg::SRC_CASSETTE;
         top_d <= 1'b0;
         cassette_solenoid <= 1'b0;
         manual_solenoid <= 1'b0;
         pickup_speed <= pickup_feed_pkg::SPEED_OFF;
         pickup_motor_on <= 1'b0;
         size_mismatch <= 1'b0;
         manual_media_absent <= 1'b0;
         feed_busy <= 1'b0;
      end else begin
         feed_state <= next_feed_state;
         feed_cnt <= next_feed_cnt;
         len_cnt <= next_len_cnt;
         exp_len <= next_exp_len;
         src <= next_src;
         top_d <= page_top;
         cassette_solenoid <= next_cas_sol;
         manual_solenoid <= next_man_sol;
         pickup_speed <= next_speed;
         pickup_motor_on <= (next_speed != pickup_feed_pkg::SPEED_OFF);
         size_mismatch <= next_mismatch;
         manual_media_absent <= next_manual_absent;
         feed_busy <= (next_feed_state != pickup_feed_pkg::FEED_IDLE);
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence cas_cmd_seq;
      feed_state == pickup_feed_pkg::FEED_IDLE && print_cmd
         && print_src == pickup_feed_pkg::SRC_CASSETTE;
   endsequence
   AST_LIFT_STOP: assert property (@(posedge clk) disable iff (!arst_n)
      lift_state == pickup_feed_pkg::LIFT_RUN && stack_hit |=> !lifter_motor)
      else $error("lifter kept running after stack sensor");
   AST_LIFT_FAIL: assert property (@(posedge clk) disable iff (!arst_n)
      lift_state == pickup_feed_pkg::LIFT_FAIL |-> lifter_fail && !lifter_motor)
      else $error("lifter failure state without flag");
   AST_CAS_SEQ: assert property (@(posedge clk) disable iff (!arst_n)
      cas_cmd_seq |=> pickup_motor_on && !cassette_solenoid)
      else $error("cassette solenoid fired without delay");
   AST_MAN_SOL: assert property (@(posedge clk) disable iff (!arst_n)
      feed_state == pickup_feed_pkg::FEED_IDLE && print_cmd
         && print_src == pickup_feed_pkg::SRC_MANUAL |=> manual_solenoid && pickup_motor_on)
      else $error("manual solenoid not driven");
   AST_ABSENT: assert property (@(posedge clk) disable iff (!arst_n)
      end_sw[0] |=> cassette_absent && paper_size == pickup_feed_pkg::SIZE_UNKNOWN)
      else $error("absence not reported");
   AST_A4: assert property (@(posedge clk) disable iff (!arst_n)
      !end_sw[0] && end_sw[2:1] == 2'b00 && width_sw == 3'b111
         |=> paper_size == pickup_feed_pkg::SIZE_A4)
      else $error("A4 decode wrong");
   AST_A3: assert property (@(posedge clk) disable iff (!arst_n)
      !end_sw[0] && end_sw[2:1] == 2'b11 && width_sw == 3'b111
         |=> paper_size == pickup_feed_pkg::SIZE_A3)
      else $error("A3 decode wrong");
   AST_MEDIA_OUT: assert property (@(posedge clk) disable iff (!arst_n)
      present && media_empty |=> media_out)
      else $error("media out not reported");
   AST_LAST: assert property (@(posedge clk) disable iff (!arst_n)
      src == pickup_feed_pkg::SRC_MANUAL && feed_state != pickup_feed_pkg::FEED_IDLE
         && last_sheet |=> manual_media_absent)
      else $error("last sheet not reported");
   AST_ALIGN: assert property (@(posedge clk) disable iff (!arst_n)
      feed_state == pickup_feed_pkg::FEED_WAIT_TOP && page_top && !top_d
         |=> pickup_speed == pickup_feed_pkg::SPEED_ALIGN)
      else $error("no align speed at page top");
   AST_MISMATCH: assert property (@(posedge clk) disable iff (!arst_n)
      feed_state == pickup_feed_pkg::FEED_MEASURE && !page_top
         |=> size_mismatch == $past(out_of_window(len_cnt, exp_len)))
      else $error("mismatch flag wrong");
endmodule : paper_pickup_feed_control

// >>> src/pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_level;
   always_comb begin
      // Stage one feeds only stage two; a change counts once two and three agree
      next_level = level;
      for (int i = 0; i < WIDTH; i++) begin
         if (stage2[i] == stage3[i]) begin
            next_level[i] = stage3[i];
         end
      end
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         level <= '0;
      end else begin
         stage1 <= pin;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
      end
   end
endmodule : pin_sync

// >>> test/formatter_model.sv
// Formatter model: issues print commands to the engine controller
`timescale 1ns/10ps
module formatter_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic go,
   input wire logic src,
   input wire logic [31:0] len,
   input wire logic feed_busy,
   output logic print_cmd,
   output logic print_src,
   output logic [31:0] expected_len
);
   // ---------------------------------------------------------------
   // Command handshake
   // ---------------------------------------------------------------
   // Command is dropped once busy is seen, so a held level never restarts a sheet
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         print_cmd <= 1'b0;
         print_src <= 1'b0;
         expected_len <= 32'h0000_0000;
      end else if (print_cmd && feed_busy) begin
         print_cmd <= 1'b0;
         print_src <= ~print_src;
         expected_len <= ~expected_len;
      end else if (go && !feed_busy && !print_cmd) begin
         print_cmd <= 1'b1;
         print_src <= src;
         expected_len <= len;
      end
   end
endmodule : formatter_model

// >>> test/paper_pickup_feed_control_tb_top.sv
// Testbench for the paper pickup and feed control block
`timescale 1ns/10ps
module paper_pickup_feed_control_tb_top;
   localparam int TOL = 20;
   localparam int SDLY = 10;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic go = 1'b0, src = 1'b0;
   logic [31:0] len = 32'h0000_0000;
   logic print_cmd, print_src;
   logic [31:0] expected_len;
   logic stack_sensor_pin = 1'b0, media_out_pin = 1'b0;
   logic last_sheet_pin = 1'b0, page_top_pin = 1'b0;
   logic [2:0] width_sw_pin = 3'h0, end_sw_pin = 3'h0;
   logic lifter_motor, lifter_fail, pickup_motor_on, cassette_solenoid, manual_solenoid;
   logic cassette_absent, media_out, manual_media_absent, size_mismatch, feed_busy;
   logic [1:0] pickup_speed;
   logic [3:0] paper_size;
   int err_count = 0, check_count = 0, n;
   int seed = 32'h3ae1f03f;
   // Entries: {width, end, expected code}
   logic [9:0] tbl [13] = '{
      {3'h7, 3'h0, pickup_feed_pkg::SIZE_A4}, {3'h3, 3'h0, pickup_feed_pkg::SIZE_LETTER},
      {3'h1, 3'h0, pickup_feed_pkg::SIZE_B5}, {3'h0, 3'h0, pickup_feed_pkg::SIZE_EXECUTIVE},
      {3'h6, 3'h0, pickup_feed_pkg::SIZE_A5R}, {3'h4, 3'h0, pickup_feed_pkg::SIZE_B5R},
      {3'h5, 3'h0, pickup_feed_pkg::SIZE_LETTER_R}, {3'h5, 3'h4, pickup_feed_pkg::SIZE_A4R},
      {3'h7, 3'h6, pickup_feed_pkg::SIZE_A3}, {3'h3, 3'h6, pickup_feed_pkg::SIZE_TABLOID},
      {3'h1, 3'h6, pickup_feed_pkg::SIZE_B4}, {3'h5, 3'h6, pickup_feed_pkg::SIZE_LEGAL},
      {3'h7, 3'h2, pickup_feed_pkg::SIZE_UNKNOWN}};

   initial begin
      forever #2 clk = ~clk;
   end

   formatter_model partner (.clk(clk), .arst_n(arst_n), .go(go), .src(src), .len(len),
      .feed_busy(feed_busy), .print_cmd(print_cmd), .print_src(print_src),
      .expected_len(expected_len));

   paper_pickup_feed_control #(.LIFT_TIMEOUT(50), .SOL_DELAY(SDLY), .SOL_ON(10),
      .ALIGN_TIME(10), .LEN_TOL(TOL)) DUT (
      .clk(clk), .arst_n(arst_n), .print_cmd(print_cmd), .print_src(print_src),
      .expected_len(expected_len), .stack_sensor_pin(stack_sensor_pin),
      .width_sw_pin(width_sw_pin), .end_sw_pin(end_sw_pin), .media_out_pin(media_out_pin),
      .last_sheet_pin(last_sheet_pin), .page_top_pin(page_top_pin),
      .lifter_motor(lifter_motor), .lifter_fail(lifter_fail),
      .pickup_motor_on(pickup_motor_on), .pickup_speed(pickup_speed),
      .cassette_solenoid(cassette_solenoid), .manual_solenoid(manual_solenoid),
      .cassette_absent(cassette_absent), .paper_size(paper_size), .media_out(media_out),
      .manual_media_absent(manual_media_absent), .size_mismatch(size_mismatch),
      .feed_busy(feed_busy));

   // ---------------------------------------------------------------
   // Compare and closing tasks
   // ---------------------------------------------------------------
   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_bit

   task automatic chk_code(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_code

   task automatic complete_run();
      if (err_count == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   // Margins keep clear of the tolerance edge, since sync latency may shift a count by one
   function automatic logic exp_mismatch(input int seen, input int want);
      return (seen > want + TOL) || (want > seen + TOL);
   endfunction : exp_mismatch

   task automatic ticks(input int k);
      repeat (k) @(negedge clk);
   endtask : ticks

   // One sheet: command, pickup, page-top pass, length verdict
   task automatic feed(input logic s, input int l, input int d);
      @(posedge clk);
      go <= 1'b1;
      src <= s;
      len <= l;
      for (n = 0; n < 20 && feed_busy !== 1'b1; n++) @(negedge clk);
      @(posedge clk) go <= 1'b0;
      @(negedge clk);
      chk_bit(pickup_motor_on, 1'b1);
      chk_code({2'h0, pickup_speed}, {2'h0, pickup_feed_pkg::SPEED_FEED});
      if (s == pickup_feed_pkg::SRC_MANUAL) begin
         chk_bit(manual_solenoid, 1'b1);
         chk_bit(manual_media_absent, 1'b0);
         @(posedge clk) last_sheet_pin <= 1'b1;
         ticks(10);
         chk_bit(manual_media_absent, 1'b1);
         @(posedge clk) last_sheet_pin <= 1'b0;
      end else begin
         chk_bit(cassette_solenoid, 1'b0);
         for (n = 1; n < 40 && cassette_solenoid !== 1'b1; n++) @(negedge clk);
         chk_bit(n >= SDLY - 1 && n <= SDLY + 1, 1'b1);
      end
      ticks(30);
      @(posedge clk) page_top_pin <= 1'b1;
      ticks(8);
      chk_code({2'h0, pickup_speed}, {2'h0, pickup_feed_pkg::SPEED_ALIGN});
      repeat (l + d - 8) @(posedge clk);
      page_top_pin <= 1'b0;
      for (n = 0; n < 40 && feed_busy !== 1'b0; n++) @(negedge clk);
      chk_bit(feed_busy, 1'b0);
      chk_bit(size_mismatch, exp_mismatch(l + d, l));
      chk_bit(pickup_motor_on, 1'b0);
   endtask : feed

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   initial begin
      #40000;
      err_count++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int l, d;
      repeat (8) @(posedge clk);
      chk_bit(lifter_motor, 1'b0);
      arst_n <= 1'b1;
      ticks(12);
      chk_bit(lifter_motor, 1'b1);
      chk_bit(cassette_absent, 1'b0);
      ticks(60);
      chk_bit(lifter_fail, 1'b1);
      chk_bit(lifter_motor, 1'b0);
      @(posedge clk) end_sw_pin <= 3'h1;
      ticks(10);
      chk_bit(cassette_absent, 1'b1);
      @(posedge clk) end_sw_pin <= 3'h0;
      ticks(12);
      chk_bit(lifter_motor, 1'b1);
      @(posedge clk) stack_sensor_pin <= 1'b1;
      ticks(10);
      chk_bit(lifter_motor, 1'b0);
      chk_bit(lifter_fail, 1'b0);
      for (int i = 0; i < 13; i++) begin
         @(posedge clk);
         width_sw_pin <= tbl[i][9:7];
         end_sw_pin <= tbl[i][6:4];
         ticks(10);
         chk_code(paper_size, tbl[i][3:0]);
      end
      @(posedge clk) media_out_pin <= 1'b1;
      ticks(10);
      chk_bit(media_out, 1'b1);
      @(posedge clk) media_out_pin <= 1'b0;
      ticks(10);
      chk_bit(media_out, 1'b0);
      feed(pickup_feed_pkg::SRC_CASSETTE, 80, 45);
      feed(pickup_feed_pkg::SRC_MANUAL, 80, -3);
      for (int i = 0; i < 6; i++) begin
         l = 60 + ($random(seed) & 63);
         d = ($random(seed) & 1) ? (40 + ($random(seed) & 7)) : ($random(seed) & 7);
         if ($random(seed) & 1) d = -d;
         feed(1'($random(seed) & 1), l, d);
      end
      complete_run();
   end
endmodule : paper_pickup_feed_control_tb_top
